// [pasc_pkg.sv]
// constants, field layouts and carriers of the phy management register bank
// assumes a plain register port: 5-bit address, 16-bit data, one-cycle strobes
// Operation
// - parallel detection fault sets expansion bit 4, latched, cleared by read
// - new page sets expansion bit 1, latched, cleared by read
// - bit 3 partner next page, bit 0 partner autoneg, bit 2 local zero
// - expansion bits 15:5 and all of register 18 read zero
// - addresses 8 to 15 are reserved and hold no function
// - status bit 13 set disables auto reduced power down, reset one
// - read-only bit 11 shows 100 Mbps deserializer in-sync, reset one
// - bits 10 and 9 show 100 and 10 Mbps power down, reset one
// - read-only bit 8 shows detected 10 Mbps receive polarity
// - bits 6:2 show phy address sampled at configuration
// - bit 1 shows resolved speed, bit 0 resolved duplex
// - special bit 15 bypasses scrambler, bit 14 bypasses 4B/5B
// - bit 13 sends H pattern, bit 12 sends 34 pattern
// - special bit 11 forces a valid 100 Mbps link
// - symbol error output driven only while special bit 10 set
// - special bit 9 suppresses 100 Mbps receive carrier sense
// - special bit 8 disables dynamic power down
// - special bit 7 runs autonegotiation in loopback
// - special bit 6 puts line transmit drivers in high impedance
// - bit 4 stops auto polarity, then bit 5 forces reversed polarity
// - bit 3 disables squelch test, bit 2 enables extended squelch
// - bit 1 disables link integrity, bit 0 disables jabber

package pasc_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_LATCH = 2;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_AN_EXP = 5'h06;
    localparam logic [ADDR_W-1:0] ADDR_RSVD_LO = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_RSVD_HI = 5'h0F;
    localparam logic [ADDR_W-1:0] ADDR_STAT_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_SPEC_CTRL = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_RSVD_18 = 5'h12;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int EXP_PDF_BIT = 4;
    localparam int EXP_LP_NP_BIT = 3;
    localparam int EXP_NP_BIT = 2;
    localparam int EXP_PR_BIT = 1;
    localparam int EXP_LP_AN_BIT = 0;
    localparam int LATCH_PDF = 0;
    localparam int LATCH_PR = 1;

    localparam int SC_RSVD_HI = 15;
    localparam int SC_RSVD_LO = 14;
    localparam int SC_RPD_DIS_BIT = 13;
    localparam int SC_RSVD_MID = 12;
    localparam int SC_SYNC_BIT = 11;
    localparam int SC_PD100_BIT = 10;
    localparam int SC_PD10_BIT = 9;
    localparam int SC_POL_BIT = 8;
    localparam int SC_ADDR_HI = 6;
    localparam int SC_ADDR_LO = 2;
    localparam int SC_SPEED_BIT = 1;
    localparam int SC_DUPLEX_BIT = 0;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [3:0] SC_RW_RST = 4'h2;
    localparam logic LOCAL_NP_ABLE = 1'b0;
    localparam logic [4:0] PHY_ADDR_RST = 5'h00;

    // special control word, msb first as it sits in the register
    typedef struct packed
    {
        logic scr_bypass;
        logic enc_bypass;
        logic tx_h_pat;
        logic tx_34_pat;
        logic force_link;
        logic sym_err_en;
        logic crs_dis;
        logic dyn_pd_dis;
        logic an_loopback;
        logic tx_tristate;
        logic force_pol_rev;
        logic auto_pol_dis;
        logic squelch_dis;
        logic ext_squelch;
        logic link_int_dis;
        logic jabber_dis;
    } pasc_ctrl_s;

    // live status from the phy units
    typedef struct packed
    {
        logic in_sync;
        logic pd_100;
        logic pd_10;
        logic pol_rev;
        logic speed_100;
        logic full_duplex;
        logic lp_np_able;
        logic lp_an_able;
    } pasc_stat_s;

    localparam pasc_stat_s STAT_RST = 8'hE0;

endpackage

// [pasc_latch.sv]
// one latched-high status bit that clears on a read of it
// assumes clr_i is the read strobe of the register that shows the bit
`timescale 1ns/1ns

module pasc_latch
    import pasc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);

    logic flag_ff;
    logic nxt_flag;

    // ---------------------------------------------------------------
    // latch and clear
    // ---------------------------------------------------------------
    // set beats clear
    // the read returns flag_ff this cycle, so only that value is dropped
    assign nxt_flag = set_i | (flag_ff & ~clr_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end

    assign flag_o = flag_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_set_survives_clear;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (set_i && clr_i) |=> flag_o;
    endproperty
    a_set_survives_clear: assert property (p_set_survives_clear)
        else $error("event lost while its flag was cleared");

    property p_held_until_read;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (flag_o && !clr_i) |=> flag_o;
    endproperty
    a_held_until_read: assert property (p_held_until_read)
        else $error("latched flag dropped without a read");

endmodule

// [pasc_regs.sv]
// management register bank: expansion, status/control, special control
// assumes inputs synchronous to clk_sys_i; events are one-cycle pulses
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns

module pasc_regs
    import pasc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic pd_fault_i,
    input wire logic page_rx_i,
    input wire pasc_stat_s stat_i,
    input wire logic [4:0] phy_addr_i,
    input wire logic link_100_i,
    input wire logic sym_err_i,
    input wire logic crs_100_i,
    output pasc_ctrl_s ctrl_o,
    output logic link_100_o,
    output logic sym_err_o,
    output logic crs_100_o,
    output logic pol_rev_o,
    output logic auto_rpd_en_o
);

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire sel_exp = (addr_i == ADDR_AN_EXP);
    wire sel_sc = (addr_i == ADDR_STAT_CTRL);
    wire sel_spec = (addr_i == ADDR_SPEC_CTRL);
    wire sel_r18 = (addr_i == ADDR_RSVD_18);
    wire sel_rsvd = (addr_i >= ADDR_RSVD_LO) && (addr_i <= ADDR_RSVD_HI);
    wire rd_exp = rd_en_i & sel_exp;
    wire wr_sc = wr_en_i & sel_sc;
    wire wr_spec = wr_en_i & sel_spec;
    pasc_ctrl_s wr_ctrl;
    assign wr_ctrl = pasc_ctrl_s'(wr_data_i);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    logic [3:0] sc_rw_ff;
    pasc_ctrl_s ctrl_ff;
    pasc_ctrl_s out_ctrl_ff;
    pasc_stat_s stat_ff;
    logic [4:0] phy_addr_ff;
    logic addr_taken_ff;
    logic link_ff;
    logic sym_err_ff;
    logic crs_ff;
    logic pol_ff;
    logic rpd_en_ff;
    logic [NUM_LATCH-1:0] latch_set;
    logic [NUM_LATCH-1:0] latch_q;

    // ---------------------------------------------------------------
    // latched event bits
    // ---------------------------------------------------------------
    // fault and new page event sources
    assign latch_set[LATCH_PDF] = pd_fault_i;
    assign latch_set[LATCH_PR] = page_rx_i;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LATCH; gi++)
        begin : g_latch
            pasc_latch u_latch
            (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .set_i(latch_set[gi]),
                .clr_i(rd_exp),
                .flag_o(latch_q[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // read words
    // ---------------------------------------------------------------
    wire [DATA_W-1:0] exp_word;
    wire [DATA_W-1:0] sc_word;

    assign exp_word = {11'h000,
                       latch_q[LATCH_PDF],
                       stat_ff.lp_np_able,
                       LOCAL_NP_ABLE,
                       latch_q[LATCH_PR],
                       stat_ff.lp_an_able};

    assign sc_word = {sc_rw_ff,
                      stat_ff.in_sync,
                      stat_ff.pd_100,
                      stat_ff.pd_10,
                      stat_ff.pol_rev,
                      1'b0,
                      phy_addr_ff,
                      stat_ff.speed_100,
                      stat_ff.full_duplex};

    // register 18 reads zero
    // unmapped addresses read zero as well
    assign nxt_rd_data = !rd_en_i ? ZERO_WORD :
                         sel_exp ? exp_word :
                         sel_sc ? sc_word :
                         sel_spec ? DATA_W'(ctrl_ff) :
                         ZERO_WORD;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            rd_data_ff <= ZERO_WORD;
        else
            rd_data_ff <= nxt_rd_data;
    end

    assign rd_data_o = rd_data_ff;

    // ---------------------------------------------------------------
    // writable registers
    // ---------------------------------------------------------------
    // power down disable, resets to one
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            sc_rw_ff <= SC_RW_RST;
        else if (wr_sc)
            sc_rw_ff <= wr_data_i[SC_RSVD_HI:SC_RSVD_MID];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            ctrl_ff <= pasc_ctrl_s'(ZERO_WORD);
        else if (wr_spec)
            ctrl_ff <= pasc_ctrl_s'(wr_data_i);
    end

    // ---------------------------------------------------------------
    // status capture
    // ---------------------------------------------------------------
    // registered so the documented reset values show until live data
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            stat_ff <= STAT_RST;
        else
            stat_ff <= stat_i;
    end

    // address strap caught once after release
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            phy_addr_ff <= PHY_ADDR_RST;
            addr_taken_ff <= 1'b0;
        end
        else if (!addr_taken_ff)
        begin
            phy_addr_ff <= phy_addr_i;
            addr_taken_ff <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // control effects
    // ---------------------------------------------------------------
    wire nxt_link;
    wire nxt_sym_err;
    wire nxt_crs;
    wire nxt_pol;
    wire nxt_rpd_en;

    assign nxt_link = link_100_i | ctrl_ff.force_link;
    assign nxt_sym_err = sym_err_i & ctrl_ff.sym_err_en;
    assign nxt_crs = crs_100_i & ~ctrl_ff.crs_dis;
    assign nxt_pol = ctrl_ff.auto_pol_dis ? ctrl_ff.force_pol_rev
                                          : stat_i.pol_rev;
    assign nxt_rpd_en = ~sc_rw_ff[SC_RPD_DIS_BIT-SC_RSVD_MID];

    // tristate, squelch, link and jabber
    // one register stage keeps every output off the write path
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            out_ctrl_ff <= pasc_ctrl_s'(ZERO_WORD);
            link_ff <= 1'b0;
            sym_err_ff <= 1'b0;
            crs_ff <= 1'b0;
            pol_ff <= 1'b0;
            rpd_en_ff <= 1'b0;
        end
        else
        begin
            out_ctrl_ff <= ctrl_ff;
            link_ff <= nxt_link;
            sym_err_ff <= nxt_sym_err;
            crs_ff <= nxt_crs;
            pol_ff <= nxt_pol;
            rpd_en_ff <= nxt_rpd_en;
        end
    end

    assign ctrl_o = out_ctrl_ff;
    assign link_100_o = link_ff;
    assign sym_err_o = sym_err_ff;
    assign crs_100_o = crs_ff;
    assign pol_rev_o = pol_ff;
    assign auto_rpd_en_o = rpd_en_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_exp_read;
        rd_en_i && sel_exp;
    endsequence

    property p_pdf_reported;
        pd_fault_i ##1 s_exp_read |=> rd_data_o[EXP_PDF_BIT];
    endproperty
    a_pdf_reported: assert property (p_pdf_reported)
        else $error("fault flag missing from read");

    property p_pr_cleared;
        (s_exp_read and !page_rx_i) |=> !latch_q[LATCH_PR];
    endproperty
    a_pr_cleared: assert property (p_pr_cleared)
        else $error("page flag not cleared by read");

    property p_exp_upper_zero;
        s_exp_read |=> (rd_data_o[DATA_W-1:EXP_PDF_BIT+1] == 11'h000)
                       && !rd_data_o[EXP_NP_BIT];
    endproperty
    a_exp_upper_zero: assert property (p_exp_upper_zero)
        else $error("expansion reserved bits not zero");

    property p_rsvd_zero;
        rd_en_i && (sel_rsvd || sel_r18) |=> rd_data_o == ZERO_WORD;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved address returned data");

    property p_rpd_write;
        wr_sc && !wr_data_i[SC_RPD_DIS_BIT] |=> ##1 auto_rpd_en_o;
    endproperty
    a_rpd_write: assert property (p_rpd_write)
        else $error("reduced power down not enabled");

    property p_addr_read;
        rd_en_i && sel_sc && addr_taken_ff
            |=> rd_data_o[SC_ADDR_HI:SC_ADDR_LO] == $past(phy_addr_ff);
    endproperty
    a_addr_read: assert property (p_addr_read)
        else $error("phy address field wrong");

    property p_tristate;
        wr_spec && wr_ctrl.tx_tristate |=> ##1 ctrl_o.tx_tristate;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("transmit drivers not tristated");

    property p_sym_gate;
        !ctrl_ff.sym_err_en |=> !sym_err_o;
    endproperty
    a_sym_gate: assert property (p_sym_gate)
        else $error("symbol error driven while disabled");

    property p_force_pol;
        ctrl_ff.auto_pol_dis && ctrl_ff.force_pol_rev |=> pol_rev_o;
    endproperty
    a_force_pol: assert property (p_force_pol)
        else $error("forced reversed polarity not applied");

    property p_force_link;
        ctrl_ff.force_link |=> link_100_o;
    endproperty
    a_force_link: assert property (p_force_link)
        else $error("forced link not shown");

    property p_pr_reported;
        page_rx_i ##1 s_exp_read |=> rd_data_o[EXP_PR_BIT];
    endproperty
    a_pr_reported: assert property (p_pr_reported)
        else $error("page flag missing from read");

    property p_crs_off;
        ctrl_ff.crs_dis |=> !crs_100_o;
    endproperty
    a_crs_off: assert property (p_crs_off)
        else $error("carrier sense shown while suppressed");

    property p_spec_store;
        wr_spec |=> DATA_W'(ctrl_ff) == $past(wr_data_i);
    endproperty
    a_spec_store: assert property (p_spec_store)
        else $error("special control write not stored");

    property p_sc_store;
        wr_sc |=> sc_rw_ff == $past(wr_data_i[SC_RSVD_HI:SC_RSVD_MID]);
    endproperty
    a_sc_store: assert property (p_sc_store)
        else $error("status control write not stored");

    property p_sync_read;
        rd_en_i && sel_sc |=> rd_data_o[SC_SYNC_BIT] == $past(stat_ff.in_sync);
    endproperty
    a_sync_read: assert property (p_sync_read)
        else $error("in-sync bit not shown");

    property p_ctrl_out;
        wr_spec |=> ##1 ctrl_o == $past(wr_data_i, 2);
    endproperty
    a_ctrl_out: assert property (p_ctrl_out)
        else $error("control outputs do not follow write");

    property p_pol_auto;
        !ctrl_ff.auto_pol_dis |=> pol_rev_o == $past(stat_i.pol_rev);
    endproperty
    a_pol_auto: assert property (p_pol_auto)
        else $error("detected polarity not passed on");

endmodule

// [pasc_mgmt_model.sv]
// management station model that drives the register port of the bank
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/1ns

module pasc_mgmt_model
    import pasc_pkg::*;
(
    input wire logic clk_sys_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wr_data_o,
    output logic wr_en_o,
    output logic rd_en_o,
    input wire logic [DATA_W-1:0] rd_data_i
);
    // ------------------------------------------------------------
    // idle state
    // ------------------------------------------------------------
    initial
    begin
        addr_o = 5'h1F;
        wr_data_o = 16'h0000;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
    end

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // released lines show the inverse, so stale values never match
    task automatic wr(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        wr_data_o <= d;
        wr_en_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_en_o <= 1'b0;
        addr_o <= ~a;
        wr_data_o <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_en_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rd_data_i;
    endtask
endmodule

// [phy_autoneg_status_ctrl_regs_tb_top.sv]
// self-checking bench for the phy management register bank
// assumes pasc_regs and pasc_mgmt_model; one 20 MHz clock
`timescale 1ns/1ns

module phy_autoneg_status_ctrl_regs_tb_top
    import pasc_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [4:0] PHY_A = 5'h15;
    logic clk_sys_i, sys_rst_i, wr_en_i, rd_en_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wr_data_i, rd_data_o;
    logic pd_fault_i, page_rx_i, link_100_i, sym_err_i, crs_100_i;
    pasc_stat_s stat_i;
    logic [4:0] phy_addr_i;
    pasc_ctrl_s ctrl_o;
    logic link_100_o, sym_err_o, crs_100_o, pol_rev_o, auto_rpd_en_o;
    logic [4:0] outs;
    int err_count = 0;
    int n_checks = 0;
    logic [15:0] oc_ctrl [3] = '{16'h0000, 16'h0E30, 16'h0010};
    logic [4:0] oc_exp [3] = '{5'h07, 5'h1B, 5'h05};
    assign outs = {link_100_o, sym_err_o, crs_100_o, pol_rev_o, auto_rpd_en_o};

    pasc_regs DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .pd_fault_i(pd_fault_i),
        .page_rx_i(page_rx_i), .stat_i(stat_i), .phy_addr_i(phy_addr_i),
        .link_100_i(link_100_i), .sym_err_i(sym_err_i),
        .crs_100_i(crs_100_i), .ctrl_o(ctrl_o), .link_100_o(link_100_o),
        .sym_err_o(sym_err_o), .crs_100_o(crs_100_o),
        .pol_rev_o(pol_rev_o), .auto_rpd_en_o(auto_rpd_en_o));

    pasc_mgmt_model MGT (.clk_sys_i(clk_sys_i), .addr_o(addr_i),
        .wr_data_o(wr_data_i), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
        .rd_data_i(rd_data_o));

    // ------------------------------------------------------------
    // expectations and compares
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_stat(input logic [3:0] w);
        return {w, stat_i.in_sync, stat_i.pd_100, stat_i.pd_10,
                stat_i.pol_rev, 1'b0, PHY_A, stat_i.speed_100,
                stat_i.full_duplex};
    endfunction

    function automatic logic [15:0] exp_exp(input logic pdf, input logic pr);
        return {11'h000, pdf, stat_i.lp_np_able, 1'b0, pr, stat_i.lp_an_able};
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: word %h wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [4:0] exp);
        n_checks++;
        if (outs !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: outputs %b wanted %b",
                     $time, outs, exp);
        end
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        MGT.rd(a, d);
        chk_word(d, exp);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, stimulus
    // ------------------------------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // run needs about 250 cycles; the margin is generous
    initial
    begin
        #(50 * 20000);
        err_count++;
        give_verdict();
    end

    initial
    begin
        logic [15:0] d, v;
        sys_rst_i = 1'b1;
        {pd_fault_i, page_rx_i, link_100_i, sym_err_i, crs_100_i} = 5'h00;
        stat_i = STAT_RST;
        phy_addr_i = PHY_A;
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        // strap is taken here; a later change must not show
        @(posedge clk_sys_i);
        phy_addr_i <= 5'h0A;
        #1;
        chk_word(ctrl_o, 16'h0000);
        chk_out(5'h00);
        rd_chk(ADDR_AN_EXP, exp_exp(1'b0, 1'b0));
        rd_chk(ADDR_STAT_CTRL, exp_stat(4'h2));
        rd_chk(ADDR_SPEC_CTRL, 16'h0000);
        for (int i = 0; i < 32; i++)
        begin
            if (i == 6 || i == 16 || i == 17)
                continue;
            MGT.wr(i[4:0], 16'hFFFF);
            rd_chk(i[4:0], 16'h0000);
        end
        foreach (oc_exp[k])
        begin
            @(posedge clk_sys_i) stat_i <= (k == 0) ? 8'h1F : 8'hAA;
            #1;
            rd_chk(ADDR_STAT_CTRL, exp_stat(4'h2));
            rd_chk(ADDR_AN_EXP, exp_exp(1'b0, 1'b0));
        end
        MGT.wr(ADDR_STAT_CTRL, 16'hFFFF);
        rd_chk(ADDR_STAT_CTRL, exp_stat(4'hF));
        MGT.wr(ADDR_STAT_CTRL, 16'h0000);
        rd_chk(ADDR_STAT_CTRL, exp_stat(4'h0));
        for (int i = 0; i < 16; i++)
        begin
            v = 16'h0001 << i;
            MGT.wr(ADDR_SPEC_CTRL, v);
            rd_chk(ADDR_SPEC_CTRL, v);
            chk_word(ctrl_o, v);
        end
        @(posedge clk_sys_i) stat_i <= 8'h10;
        {link_100_i, sym_err_i, crs_100_i} <= 3'h3;
        foreach (oc_ctrl[k])
        begin
            MGT.wr(ADDR_SPEC_CTRL, oc_ctrl[k]);
            @(posedge clk_sys_i);
            #1;
            chk_out(oc_exp[k]);
        end
        @(posedge clk_sys_i);
        pd_fault_i <= 1'b1;
        @(posedge clk_sys_i);
        pd_fault_i <= 1'b0;
        rd_chk(ADDR_AN_EXP, exp_exp(1'b1, 1'b0));
        rd_chk(ADDR_AN_EXP, exp_exp(1'b0, 1'b0));
        @(posedge clk_sys_i);
        page_rx_i <= 1'b1;
        @(posedge clk_sys_i);
        page_rx_i <= 1'b0;
        rd_chk(ADDR_AN_EXP, exp_exp(1'b0, 1'b1));
        rd_chk(ADDR_AN_EXP, exp_exp(1'b0, 1'b0));
        @(posedge clk_sys_i);
        {pd_fault_i, page_rx_i} <= 2'h3;
        @(posedge clk_sys_i);
        {pd_fault_i, page_rx_i} <= 2'h0;
        // new fault arrives in the very cycle the read is taken
        fork
            MGT.rd(ADDR_AN_EXP, d);
            begin
                @(posedge clk_sys_i);
                pd_fault_i <= 1'b1;
                @(posedge clk_sys_i);
                pd_fault_i <= 1'b0;
            end
        join
        chk_word(d, exp_exp(1'b1, 1'b1));
        rd_chk(ADDR_AN_EXP, exp_exp(1'b1, 1'b0));
        rd_chk(ADDR_AN_EXP, exp_exp(1'b0, 1'b0));
        give_verdict();
    end
endmodule
